/* core/ahap_pkg.sv */
// package for the asynchronous host access port: constants and carrier types
package ahap_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int AHAP_ADDR_W = 32;
  localparam int AHAP_DATA_W = 48;
  localparam int AHAP_MSEL_W = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int AHAP_CLK_PERIOD_PS = 10000;
  // least ready low pulse on a write, in ns
  localparam int AHAP_WR_RDY_LOW_NS = 15;
  localparam int AHAP_WR_RDY_CYC =
    (AHAP_WR_RDY_LOW_NS * 1000 + AHAP_CLK_PERIOD_PS - 1) / AHAP_CLK_PERIOD_PS;
  // least ready low pulse on a read, in ns (the clock-dependent part is covered by the edge)
  localparam int AHAP_RD_RDY_LOW_NS = 45;
  localparam int AHAP_RD_RDY_CYC =
    (AHAP_RD_RDY_LOW_NS * 1000 + AHAP_CLK_PERIOD_PS - 1) / AHAP_CLK_PERIOD_PS;
  localparam int AHAP_CNT_W = 8;
  localparam logic [AHAP_CNT_W-1:0] AHAP_CNT_ONE = 8'h01;
  localparam logic [AHAP_CNT_W-1:0] AHAP_CNT_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // memory interface outputs; all but the boot select float together, the boot select only in EPROM boot
  typedef struct packed {
    logic [AHAP_ADDR_W-1:0] addr;
    logic [AHAP_MSEL_W-1:0] memory_select_n;
    logic rd_n;
    logic wr_n;
    logic sync_write_select_n;
    logic page;
    logic dma_grant_n;
    logic boot_memory_select_n;
  } ahap_mem_if_t;

  // host side strobes and address
  typedef struct packed {
    logic cs_n;
    logic host_bus_request_n;
    logic rd_n;
    logic wr_n;
    logic [AHAP_ADDR_W-1:0] addr;
  } ahap_host_t;

  // one internal transfer
  typedef struct packed {
    logic wr;
    logic [AHAP_ADDR_W-1:0] addr;
    logic [AHAP_DATA_W-1:0] wdata;
  } ahap_xfer_t;

  typedef enum logic [2:0] {
    AHAP_IDLE,
    AHAP_HOLD,
    AHAP_FLOAT,
    AHAP_GRANTED,
    AHAP_ACCESS,
    AHAP_FINISH,
    AHAP_RELEASE
  } ahap_state_t;

endpackage

/* core/ahap_ready_drv.sv */
// ready pin driver with open-drain or active-drive style
`timescale 1ns/1ps
module ahap_ready_drv
  import ahap_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // control
  input wire logic active_drive_in,
  input wire logic hold_low_in,
  input wire logic host_present_in,
  // pin
  output logic host_ready_out,
  output logic host_ready_oe_n_out
);

  logic low_r;
  logic drive_high_r;
  logic drive_high_nxt;

  assign drive_high_nxt = active_drive_in & host_present_in & ~hold_low_in;

  // ----------------------------------------------------------------
  // pin state changes only on clock edges
  // ----------------------------------------------------------------
  // clocked release
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_r <= 1'b0;
      drive_high_r <= 1'b0;
    end else begin
      low_r <= hold_low_in;
      drive_high_r <= drive_high_nxt;
    end
  end

  assign host_ready_out = ~low_r;
  assign host_ready_oe_n_out = ~(low_r | drive_high_r);

endmodule

/* core/ahap_top.sv */
// asynchronous host access port and memory interface three-state control
//
// How it works
// - after grant host strobes reach internal space
// - read pulls ready low until data valid
// - write pulls ready low; host waits release
// - ready open-drain or actively driven high
// - ready released on clock edge
// - memory interface floats before grant, after release
// - floating also on software three-state input
// - strobe group floats and returns together
// - boot select floats only in EPROM boot
// - ready low once select and request low
// - grant delayed by wait states or lock
`timescale 1ns/1ps
module ahap_top
  import ahap_pkg::*;
#(
  parameter int WR_RDY_CYC = AHAP_WR_RDY_CYC,
  parameter int RD_RDY_CYC = AHAP_RD_RDY_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // host pins
  input wire ahap_host_t host_in,
  input wire logic [AHAP_DATA_W-1:0] host_data_in,
  output logic [AHAP_DATA_W-1:0] host_data_out,
  output logic host_data_oe_n_out,
  output logic host_ready_out,
  output logic host_ready_oe_n_out,
  output logic host_bus_grant_n_out,
  output logic host_bus_grant_oe_n_out,
  // configuration straps and software three-state
  input wire logic ready_active_drive_in,
  input wire logic eprom_boot_in,
  input wire logic suspend_three_state_n_in,
  input wire logic bus_hold_off_in,
  // memory interface from the bus master logic
  input wire ahap_mem_if_t mem_if_in,
  output ahap_mem_if_t mem_if_out,
  output logic mem_addr_oe_n_out,
  output logic mem_strobe_oe_n_out,
  output logic boot_select_oe_n_out,
  // internal memory and io register port
  output ahap_xfer_t xfer_out,
  output logic xfer_valid_out,
  input wire logic xfer_done_in,
  input wire logic [AHAP_DATA_W-1:0] xfer_rdata_in
);

  ahap_state_t state_r;
  ahap_state_t state_nxt;
  logic [AHAP_CNT_W-1:0] cnt_r;
  logic [AHAP_CNT_W-1:0] cnt_nxt;
  logic float_r;
  logic grant_r;
  logic sw_float_r;
  ahap_xfer_t xfer_r;
  logic xfer_valid_r;
  logic [AHAP_DATA_W-1:0] rdata_r;
  logic rdata_oe_r;
  logic done_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire host_present = ~host_in.cs_n & ~host_in.host_bus_request_n;
  wire strobe_low = ~host_in.rd_n | ~host_in.wr_n;
  wire strobes_high = host_in.rd_n & host_in.wr_n;
  wire sw_float = ~suspend_three_state_n_in;
  wire [AHAP_CNT_W-1:0] rd_len = AHAP_CNT_W'(RD_RDY_CYC);
  wire [AHAP_CNT_W-1:0] wr_len = AHAP_CNT_W'(WR_RDY_CYC);
  wire cnt_zero = (cnt_r == AHAP_CNT_ZERO);

  wire hold_pre_grant = host_present &
    ((state_r == AHAP_IDLE) | (state_r == AHAP_HOLD) | (state_r == AHAP_FLOAT));
  wire hold_access = (state_r == AHAP_ACCESS) | (state_r == AHAP_FINISH & ~cnt_zero);
  wire ready_low = hold_pre_grant | hold_access |
    (state_r == AHAP_GRANTED & host_present & strobe_low);

  // ----------------------------------------------------------------
  // host access sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (!cnt_zero) begin
      cnt_nxt = cnt_r - AHAP_CNT_ONE;
    end
    unique case (state_r)
      AHAP_IDLE: begin
        if (host_present) begin
          state_nxt = AHAP_HOLD;
        end
      end
      // wait out wait states or lock
      AHAP_HOLD: begin
        if (!host_present) begin
          state_nxt = AHAP_IDLE;
        end else if (!bus_hold_off_in) begin
          state_nxt = AHAP_FLOAT;
        end
      end
      AHAP_FLOAT: begin
        state_nxt = host_present ? AHAP_GRANTED : AHAP_RELEASE;
      end
      AHAP_GRANTED: begin
        if (host_in.host_bus_request_n) begin
          state_nxt = AHAP_RELEASE;
        end else if (host_present & strobe_low) begin
          state_nxt = AHAP_ACCESS;
          cnt_nxt = host_in.wr_n ? rd_len : wr_len;
        end
      end
      AHAP_ACCESS: begin
        if (xfer_done_in) begin
          state_nxt = AHAP_FINISH;
        end
      end
      AHAP_FINISH: begin
        if (cnt_zero & strobes_high) begin
          state_nxt = AHAP_GRANTED;
        end
      end
      AHAP_RELEASE: begin
        state_nxt = AHAP_IDLE;
      end
      default: begin
        state_nxt = AHAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= AHAP_IDLE;
      cnt_r <= AHAP_CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // grant and three-state control
  // ----------------------------------------------------------------
  wire grant_nxt = (state_nxt == AHAP_GRANTED) | (state_nxt == AHAP_ACCESS) |
    (state_nxt == AHAP_FINISH);
  wire float_nxt = sw_float | grant_nxt | (state_nxt == AHAP_FLOAT) |
    (state_nxt == AHAP_RELEASE);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      float_r <= 1'b0;
      grant_r <= 1'b0;
      sw_float_r <= 1'b0;
    end else begin
      float_r <= float_nxt;
      grant_r <= grant_nxt;
      sw_float_r <= sw_float;
    end
  end

  assign host_bus_grant_n_out = ~grant_r;
  // grant pin floats on the sampled software input, never while granted
  assign host_bus_grant_oe_n_out = sw_float_r & ~grant_r;
  assign mem_if_out = mem_if_in;
  assign mem_addr_oe_n_out = float_r;
  assign mem_strobe_oe_n_out = float_r;
  // boot select only in EPROM boot
  assign boot_select_oe_n_out = eprom_boot_in & float_r;

  // ----------------------------------------------------------------
  // internal transfer and read data
  // ----------------------------------------------------------------
  // strobes act only once granted
  wire start = (state_r == AHAP_GRANTED) & (state_nxt == AHAP_ACCESS);
  wire finish = (state_r == AHAP_ACCESS) & xfer_done_in;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xfer_r <= '0;
      xfer_valid_r <= 1'b0;
      rdata_r <= '0;
      rdata_oe_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (start) begin
        xfer_r <= '{wr: ~host_in.wr_n, addr: host_in.addr, wdata: host_data_in};
      end
      xfer_valid_r <= start | (xfer_valid_r & ~xfer_done_in);
      if (finish & ~xfer_r.wr) begin
        rdata_r <= xfer_rdata_in;
      end
      // data driven while the read strobe stays low
      rdata_oe_r <= (finish & ~xfer_r.wr) | (rdata_oe_r & ~host_in.rd_n);
      done_r <= finish;
    end
  end

  assign xfer_out = xfer_r;
  assign xfer_valid_out = xfer_valid_r;
  assign host_data_out = rdata_r;
  assign host_data_oe_n_out = ~rdata_oe_r;

  // ----------------------------------------------------------------
  // ready pin
  // ----------------------------------------------------------------
  ahap_ready_drv u_ready (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .active_drive_in(ready_active_drive_in),
    .hold_low_in(ready_low),
    .host_present_in(host_present),
    .host_ready_out(host_ready_out),
    .host_ready_oe_n_out(host_ready_oe_n_out)
  );

endmodule

/* sim/ahap_props.sv */
// concurrent checks on the host access port top
`timescale 1ns/1ps
module ahap_props
  import ahap_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire ahap_host_t host_in,
  input wire logic host_ready_out,
  input wire logic host_bus_grant_n_out,
  input wire logic suspend_three_state_n_in,
  input wire logic bus_hold_off_in,
  input wire logic eprom_boot_in,
  input wire logic mem_addr_oe_n_out,
  input wire logic mem_strobe_oe_n_out,
  input wire logic boot_select_oe_n_out
);
  wire pres = !host_in.cs_n && !host_in.host_bus_request_n;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_ready_on_request: assert property (
    $rose(pres) |=> !host_ready_out) else $error("ready not pulled low");
  a_grant_latency: assert property (
    ($rose(pres) && !bus_hold_off_in) ##1 (pres && !bus_hold_off_in) [*2]
    |-> ##[1:2] !host_bus_grant_n_out) else $error("grant late");
  a_hold_delays_grant: assert property (
    (bus_hold_off_in && host_bus_grant_n_out) [*2] |=> host_bus_grant_n_out)
    else $error("grant during hold off");
  a_float_before_grant: assert property (
    $fell(host_bus_grant_n_out) |-> $past(mem_addr_oe_n_out)) else $error("driven at grant");
  a_grant_release: assert property (
    ($rose(host_in.host_bus_request_n) && !host_bus_grant_n_out) |-> ##[1:2] host_bus_grant_n_out)
    else $error("grant kept");
  a_iface_returns: assert property (
    ($rose(host_bus_grant_n_out) && suspend_three_state_n_in && $past(suspend_three_state_n_in))
    |-> ##[1:2] !mem_addr_oe_n_out) else $error("interface not back");
  a_strobe_group: assert property (
    mem_strobe_oe_n_out == mem_addr_oe_n_out) else $error("strobe group split");
  a_boot_select: assert property (
    $stable(eprom_boot_in) [*2] |-> boot_select_oe_n_out == (eprom_boot_in && mem_strobe_oe_n_out))
    else $error("boot select float wrong");
  a_sw_float: assert property (
    !suspend_three_state_n_in [*3] |-> mem_addr_oe_n_out) else $error("no float on suspend");
endmodule

/* sim/ahap_host_model.sv */
// host processor model on the parallel bus
`timescale 1ns/1ps
module ahap_host_model
  import ahap_pkg::*;
(
  input wire logic clock_in,
  input wire logic ready_in,
  input wire logic grant_n_in,
  input wire logic [AHAP_DATA_W-1:0] data_in,
  output ahap_host_t host_out,
  output logic [AHAP_DATA_W-1:0] data_out
);
  int n_stall = 0;
  initial begin
    host_out = {4'hF, 32'h0000_0000};
    data_out = 48'h0;
  end
  // select and request stay low for the whole sequence
  task automatic request();
    @(posedge clock_in);
    host_out.cs_n <= 1'b0;
    host_out.host_bus_request_n <= 1'b0;
  endtask
  // upper address line high as soon as grant is seen
  task automatic wait_grant();
    int n;
    n = 0;
    do begin @(posedge clock_in); n++; end while (grant_n_in !== 1'b0 && n < 50);
    if (n >= 50) n_stall++;
    host_out.addr <= 32'h8000_0000;
  endtask
  // strobe held until ready is released, data taken at that edge
  task automatic access(input logic wr, input logic [31:0] a, input logic [47:0] d,
                        output logic [47:0] q);
    int n;
    @(posedge clock_in);
    host_out.addr <= a;
    data_out <= d;
    if (wr) host_out.wr_n <= 1'b0;
    else host_out.rd_n <= 1'b0;
    n = 0;
    do begin @(posedge clock_in); n++; end while (ready_in !== 1'b0 && n < 10);
    do begin @(posedge clock_in); n++; end while (ready_in !== 1'b1 && n < 60);
    if (n >= 60) n_stall++;
    q = data_in;
    host_out.rd_n <= 1'b1;
    host_out.wr_n <= 1'b1;
    data_out <= ~d;
    @(posedge clock_in);
  endtask
  task automatic release_bus();
    @(posedge clock_in);
    host_out.cs_n <= 1'b1;
    host_out.host_bus_request_n <= 1'b1;
  endtask
endmodule

/* sim/async_host_access_port_tb.sv */
// self-checking bench for the host access port
`timescale 1ns/1ps
module async_host_access_port_tb;
  import ahap_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic act = 1'b1, boot = 1'b0, susp_n = 1'b1, hold = 1'b0, done = 1'b0;
  logic [47:0] rdata = 48'h0, hdin, hdo, last_wdata = 48'h0;
  logic hd_oe_n, rdy, rdy_oe_n, gnt, gnt_oe_n, a_oe_n, s_oe_n, b_oe_n, xv;
  ahap_host_t host;
  ahap_mem_if_t mem_in = '0;
  ahap_mem_if_t mem_out;
  ahap_xfer_t xfer;
  int n_mismatch = 0, num_checks = 0, n_xfer = 0;
  // open-drain lines float high through their pull-ups
  wire rdy_w = rdy_oe_n ? 1'b1 : rdy;
  wire gnt_w = gnt_oe_n ? 1'b1 : gnt;
  wire [47:0] hd_w = hd_oe_n ? ~hdo : hdo;
  always #5 clock_in = ~clock_in;
  ahap_top #(.WR_RDY_CYC(2), .RD_RDY_CYC(5)) i_ahap_top (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .host_in(host), .host_data_in(hdin), .host_data_out(hdo),
    .host_data_oe_n_out(hd_oe_n), .host_ready_out(rdy), .host_ready_oe_n_out(rdy_oe_n),
    .host_bus_grant_n_out(gnt), .host_bus_grant_oe_n_out(gnt_oe_n),
    .ready_active_drive_in(act), .eprom_boot_in(boot), .suspend_three_state_n_in(susp_n),
    .bus_hold_off_in(hold), .mem_if_in(mem_in), .mem_if_out(mem_out),
    .mem_addr_oe_n_out(a_oe_n), .mem_strobe_oe_n_out(s_oe_n), .boot_select_oe_n_out(b_oe_n),
    .xfer_out(xfer), .xfer_valid_out(xv), .xfer_done_in(done), .xfer_rdata_in(rdata));
  ahap_host_model i_ahap_host_model (.clock_in(clock_in), .ready_in(rdy_w), .grant_n_in(gnt_w),
    .data_in(hd_w), .host_out(host), .data_out(hdin));
  // internal memory answers one cycle after each transfer request
  always @(posedge clock_in) begin
    done <= 1'b0;
    if (xv === 1'b1 && !done) begin
      done <= 1'b1;
      rdata <= {16'h5A5A, xfer.addr};
      n_xfer <= n_xfer + 1;
      if (xfer.wr) last_wdata <= xfer.wdata;
    end
  end
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_grant();
    @(posedge clock_in) hold <= 1'b1;
    i_ahap_host_model.request();
    repeat (6) @(posedge clock_in);
    check("grant", gnt_w, 1'b1);
    check("ready", rdy_w, 1'b0);
    check("xfer", xv, 1'b0);
    hold <= 1'b0;
    i_ahap_host_model.wait_grant();
    check("addr_oe", a_oe_n, 1'b1);
    $display("test grant done");
  endtask
  task automatic t_xfer(input logic style);
    logic [47:0] q;
    logic [47:0] wd;
    logic [31:0] ra;
    int n0;
    @(posedge clock_in) act <= style;
    n0 = n_xfer;
    wd = style ? 48'h1234_5678_9ABC : 48'hFEDC_BA98_7654;
    ra = style ? 32'h8000_0024 : 32'h8000_0038;
    i_ahap_host_model.access(1'b1, 32'h8000_0010, wd, q);
    check("wdata", last_wdata, wd);
    i_ahap_host_model.access(1'b0, ra, 48'h0, q);
    check("rdata", q, {16'h5A5A, ra});
    check("xfers", n_xfer - n0, 48'h2);
    check("ready_oe", rdy_oe_n, {47'h0, ~style});
    $display("test transfer done");
  endtask
  task automatic t_release();
    i_ahap_host_model.release_bus();
    repeat (3) @(posedge clock_in);
    check("grant", gnt_w, 1'b1);
    check("addr_oe", a_oe_n, 1'b0);
    check("mem_out", mem_out, mem_in);
    $display("test release done");
  endtask
  task automatic t_float(input logic b);
    @(posedge clock_in) boot <= b;
    susp_n <= 1'b0;
    repeat (4) @(posedge clock_in);
    check("addr_oe", a_oe_n, 1'b1);
    check("strobe_oe", s_oe_n, 1'b1);
    check("boot_oe", b_oe_n, b);
    check("grant_oe", gnt_oe_n, 1'b1);
    susp_n <= 1'b1;
    repeat (4) @(posedge clock_in);
    check("addr_oe", a_oe_n, 1'b0);
    check("grant_oe", gnt_oe_n, 1'b0);
    $display("test float done");
  endtask
  task automatic t_regrant();
    @(posedge clock_in) hold <= 1'b0;
    i_ahap_host_model.request();
    repeat (4) @(posedge clock_in);
    check("grant", gnt_w, 1'b0);
    check("addr_oe", a_oe_n, 1'b1);
    i_ahap_host_model.release_bus();
    repeat (3) @(posedge clock_in);
    check("grant", gnt_w, 1'b1);
    $display("test regrant done");
  endtask
  initial begin
    mem_in = {32'hC0DE_0001, 4'hE, 6'h3D};
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_grant();
    t_xfer(1'b1);
    t_xfer(1'b0);
    t_release();
    t_float(1'b0);
    t_float(1'b1);
    t_regrant();
    check("stalls", i_ahap_host_model.n_stall, 48'h0);
    tally_and_finish();
  end
  initial begin
    #100us;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
bind ahap_top ahap_props i_ahap_props (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .host_in(host_in), .host_ready_out(host_ready_out), .host_bus_grant_n_out(host_bus_grant_n_out),
  .suspend_three_state_n_in(suspend_three_state_n_in), .bus_hold_off_in(bus_hold_off_in),
  .eprom_boot_in(eprom_boot_in), .mem_addr_oe_n_out(mem_addr_oe_n_out),
  .mem_strobe_oe_n_out(mem_strobe_oe_n_out), .boot_select_oe_n_out(boot_select_oe_n_out));
